// File: src/ptm_pkg.sv
package ptm_pkg;
    // Register indices on the plain register port
    localparam logic [2:0] REG_CTRL     = 3'h0;
    localparam logic [2:0] REG_CNT_LO   = 3'h1;
    localparam logic [2:0] REG_CNT_HI   = 3'h2;
    localparam logic [2:0] REG_PER_LO   = 3'h3;
    localparam logic [2:0] REG_PER_HI   = 3'h4;
    localparam logic [2:0] REG_STATUS   = 3'h5;
    // Control register fields
    localparam int         CTL_RUN      = 0;
    localparam int         CTL_CS       = 1;
    localparam int         CTL_SYNC_BYP = 2;
    localparam int         CTL_PS_LO    = 3;
    localparam int         CTL_ONE_SHOT = 5;
    localparam int         CTL_TRG_DIS  = 6;
    localparam int         CTL_SLP_EN   = 7;
    localparam int         STS_MATCH    = 0;
    // Reset values
    localparam logic [7:0] CTRL_RST     = 8'h00;
    localparam logic [7:0] BYTE_RST     = 8'h00;
    localparam logic [7:0] PER_RST      = 8'hff;
    localparam logic [15:0] CNT_MAX     = 16'hffff;
    localparam logic [15:0] CNT_ZERO    = 16'h0000;
    // Quadrature phase numbering of one instruction cycle
    localparam logic [1:0] PH_Q1        = 2'h0;
    localparam logic [1:0] PH_Q2        = 2'h1;
    localparam logic [1:0] PH_Q3        = 2'h2;
    localparam logic [1:0] PH_Q4        = 2'h3;
    // Synchroniser sample pattern: old low, two new highs
    localparam logic [2:0] RISE_PAT     = 3'h3;
endpackage

// File: src/ptm_timer.sv
// What this block does
// - Timer counts only while run bit set
// - Sleep enable bit keeps async external count running asleep
// - Trigger disable bit blocks trigger reset input
// - Mode bit picks single-shot or continuous
// - Two-bit prescale divides by 1,2,4,8
// - Sync bypass bit skips external input synchroniser
// - Source bit picks external edges or cycles
// - Sleep counting needs sync bypass set
// - Low byte direct, high byte via buffer
// - Period match wraps count, sets flag
// - Internal source increments on phase Q1
// - Sync input sampled Q2/Q4, counts next Q1
// - Async mode counts raw external edges
// - Count kept when stopped, software loadable
// - Period writes accepted while running
// - Continuous mode wraps at match or FFFF
// - Single-shot match clears run bit
// - Single-shot starts by run or trigger
// - Low byte read latches high byte buffer
// - Low byte write loads buffered high byte
// - Prescaler cleared on count write, stop, trigger, reset
// - Control writes leave count untouched
// - Bus count write beats trigger reset
`timescale 1ns/1ns
`default_nettype none
module ptm_timer #(
    parameter bit HAS_TRIG_RESET = 1'b1
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic [2:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    input  wire logic       i_ext_count,
    input  wire logic       i_trig_reset,
    input  wire logic       i_sleep,
    output logic      [7:0] o_rdata,
    output logic            o_match_flag,
    output logic            o_running
);
    logic [1:0]  ph_q;
    logic [7:0]  ctl_q;
    logic [7:0]  ctl_d;
    logic [15:0] cnt_q;
    logic [7:0]  hi_buf_q;
    logic [7:0]  per_lo_q;
    logic [7:0]  per_hi_q;
    logic        flag_q;
    logic [7:0]  rdata_q;
    logic        ext_prev_q;
    logic [2:0]  smp_q;
    logic        pend_q;
    logic [2:0]  pre_q;
    logic [2:0]  pre_mask;
    logic        wr_ctl;
    logic        wr_lo;
    logic        run;
    logic        active;
    logic        src_tick;
    logic        cnt_tick;
    logic        at_top;
    logic        wrap;
    logic        trig;
    logic        trig_start;
    logic        smp_rise;
    logic        q1;

    assign wr_ctl = i_wr && (i_addr == ptm_pkg::REG_CTRL);
    assign wr_lo  = i_wr && (i_addr == ptm_pkg::REG_CNT_LO);
    assign run    = ctl_q[ptm_pkg::CTL_RUN];
    assign q1     = (ph_q == ptm_pkg::PH_Q1);

    // Instruction cycle phases, one clock each
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ph_q <= ptm_pkg::PH_Q1;
        end else begin
            ph_q <= ph_q + 2'h1;
        end
    end

    // Trigger is honoured only when implemented and enabled
    assign trig = HAS_TRIG_RESET && i_trig_reset
                  && !ctl_q[ptm_pkg::CTL_TRG_DIS];
    assign trig_start = trig && !run
                        && ctl_q[ptm_pkg::CTL_ONE_SHOT];

    // Asleep, only an unsynchronised external count may go on
    assign active = run && (!i_sleep
                    || (ctl_q[ptm_pkg::CTL_SLP_EN]
                        && ctl_q[ptm_pkg::CTL_CS]
                        && ctl_q[ptm_pkg::CTL_SYNC_BYP]));

    // External samples on Q2 and Q4; old sample low, two newer high
    assign smp_rise = (smp_q == ptm_pkg::RISE_PAT);
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            smp_q      <= 3'h0;
            pend_q     <= 1'b0;
            ext_prev_q <= 1'b0;
        end else begin
            ext_prev_q <= i_ext_count;
            if (ph_q == ptm_pkg::PH_Q2 || ph_q == ptm_pkg::PH_Q4) begin
                smp_q <= {smp_q[1:0], i_ext_count};
            end
            // Pending edge is consumed at Q1; the Q1 clear beats a fresh one
            if (smp_rise && !q1) begin
                pend_q <= 1'b1;
            end else if (q1) begin
                pend_q <= 1'b0;
            end
        end
    end

    // Pick the count source
    always_comb begin
        if (!ctl_q[ptm_pkg::CTL_CS]) begin
            src_tick = q1;
        end else if (ctl_q[ptm_pkg::CTL_SYNC_BYP]) begin
            src_tick = i_ext_count && !ext_prev_q;
        end else begin
            src_tick = q1 && pend_q;
        end
    end

    // Prescaler passes every 1, 2, 4 or 8 source ticks
    assign pre_mask = 3'((4'h1 << ctl_q[ptm_pkg::CTL_PS_LO +: 2]) - 4'h1);
    assign cnt_tick = active && src_tick
                      && ((pre_q & pre_mask) == pre_mask);
    assign at_top   = (cnt_q == {per_hi_q, per_lo_q})
                      || (cnt_q == ptm_pkg::CNT_MAX);
    assign wrap     = cnt_tick && at_top;

    // Prescaler stops and clears with run or a count write
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pre_q <= 3'h0;
        end else if (wr_lo || !run || trig) begin
            pre_q <= 3'h0;
        end else if (active && src_tick) begin
            pre_q <= cnt_tick ? 3'h0 : pre_q + 3'h1;
        end
    end

    // Counter; a bus write outranks the trigger reset
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_q <= ptm_pkg::CNT_ZERO;
        end else if (wr_lo) begin
            cnt_q <= {hi_buf_q, i_wdata};
        end else if (trig) begin
            cnt_q <= ptm_pkg::CNT_ZERO;
        end else if (wrap) begin
            cnt_q <= ptm_pkg::CNT_ZERO;
        end else if (cnt_tick) begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    // Control: software write wins over the hardware run bit
    always_comb begin
        ctl_d = ctl_q;
        if (wrap && ctl_q[ptm_pkg::CTL_ONE_SHOT]) begin
            ctl_d[ptm_pkg::CTL_RUN] = 1'b0;
        end
        if (trig_start) begin
            ctl_d[ptm_pkg::CTL_RUN] = 1'b1;
        end
        if (wr_ctl) begin
            ctl_d = i_wdata;
            ctl_d[ptm_pkg::CTL_TRG_DIS] = HAS_TRIG_RESET
                && i_wdata[ptm_pkg::CTL_TRG_DIS];
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ctl_q <= ptm_pkg::CTRL_RST;
        end else begin
            ctl_q <= ctl_d;
        end
    end

    // High buffer and period bytes; period never locked out
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            hi_buf_q <= ptm_pkg::BYTE_RST;
            per_lo_q <= ptm_pkg::PER_RST;
            per_hi_q <= ptm_pkg::PER_RST;
        end else begin
            if (i_rd && i_addr == ptm_pkg::REG_CNT_LO) begin
                hi_buf_q <= cnt_q[15:8];
            end else if (i_wr && i_addr == ptm_pkg::REG_CNT_HI) begin
                hi_buf_q <= i_wdata;
            end
            if (i_wr && i_addr == ptm_pkg::REG_PER_LO) begin
                per_lo_q <= i_wdata;
            end
            if (i_wr && i_addr == ptm_pkg::REG_PER_HI) begin
                per_hi_q <= i_wdata;
            end
        end
    end

    // Sticky flag: write one clears, a new match wins
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            flag_q <= 1'b0;
        end else if (wrap) begin
            flag_q <= 1'b1;
        end else if (i_wr && i_addr == ptm_pkg::REG_STATUS
                     && i_wdata[ptm_pkg::STS_MATCH]) begin
            flag_q <= 1'b0;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rdata_q <= ptm_pkg::BYTE_RST;
        end else if (i_rd) begin
            unique case (i_addr)
                ptm_pkg::REG_CTRL:   rdata_q <= ctl_q;
                ptm_pkg::REG_CNT_LO: rdata_q <= cnt_q[7:0];
                ptm_pkg::REG_CNT_HI: rdata_q <= hi_buf_q;
                ptm_pkg::REG_PER_LO: rdata_q <= per_lo_q;
                ptm_pkg::REG_PER_HI: rdata_q <= per_hi_q;
                ptm_pkg::REG_STATUS: rdata_q <= {7'h00, flag_q};
                default:             rdata_q <= ptm_pkg::BYTE_RST;
            endcase
        end else begin
            rdata_q <= ptm_pkg::BYTE_RST;
        end
    end

    assign o_rdata      = rdata_q;
    assign o_match_flag = flag_q;
    assign o_running    = ctl_q[ptm_pkg::CTL_RUN];

    // Stopped timer holds its count
    a_hold_stopped: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (!run && !wr_lo && !trig) |=> $stable(cnt_q))
        else $error("count moved while stopped");

    a_sleep_gate: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (i_sleep && !ctl_q[ptm_pkg::CTL_SYNC_BYP] && !wr_lo && !trig)
        |=> $stable(cnt_q))
        else $error("count moved in sleep without bypass");

    a_wrap_flag: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (wrap && !wr_lo && !trig) |=> (cnt_q == 16'h0000) && flag_q)
        else $error("match did not clear count and set flag");

    a_flag_sticky: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (flag_q && !(i_wr && i_addr == ptm_pkg::REG_STATUS)) |=> flag_q)
        else $error("flag dropped without clear");

    a_oneshot_stop: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (wrap && ctl_q[ptm_pkg::CTL_ONE_SHOT] && !wr_ctl) |=> !run)
        else $error("single shot did not stop");

    a_cont_keeps: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (wrap && !ctl_q[ptm_pkg::CTL_ONE_SHOT] && !wr_ctl) |=> run)
        else $error("continuous mode stopped");

    a_hi_latch: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (i_rd && i_addr == ptm_pkg::REG_CNT_LO)
        |=> hi_buf_q == $past(cnt_q[15:8]))
        else $error("high buffer not latched on low read");

    a_lo_write: assert property (
        @(posedge i_clk) disable iff (i_rst)
        wr_lo |=> cnt_q == {$past(hi_buf_q), $past(i_wdata)}
                  && pre_q == 3'h0)
        else $error("count write lost or prescaler kept");

    a_ctl_write: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (wr_ctl && !cnt_tick && !trig) |=> $stable(cnt_q))
        else $error("control write changed count");

    a_int_q1: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (cnt_tick && !ctl_q[ptm_pkg::CTL_CS]) |-> q1)
        else $error("internal count off Q1");

    // Running undivided internal count must step at every Q1
    a_int_ticks: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (run && !i_sleep && !ctl_q[ptm_pkg::CTL_CS] && q1
         && ctl_q[ptm_pkg::CTL_PS_LO +: 2] == 2'h0) |-> cnt_tick)
        else $error("running timer missed a Q1 step");

    // Sleep without its enable bit freezes the count
    a_sleep_stop: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (i_sleep && !ctl_q[ptm_pkg::CTL_SLP_EN] && !wr_lo && !trig)
        |=> $stable(cnt_q))
        else $error("count moved in sleep without enable");

    // Disabled trigger input has no effect
    a_trig_off: assert property (
        @(posedge i_clk) disable iff (i_rst)
        ctl_q[ptm_pkg::CTL_TRG_DIS] |-> !trig)
        else $error("trigger honoured while disabled");

    // Only single-shot mode may be started by the trigger
    a_cont_no_start: assert property (
        @(posedge i_clk) disable iff (i_rst)
        !ctl_q[ptm_pkg::CTL_ONE_SHOT] |-> !trig_start)
        else $error("trigger started continuous mode");

    // Divide by eight steps only after eight source ticks
    a_presc_eight: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (cnt_tick && ctl_q[ptm_pkg::CTL_PS_LO +: 2] == 2'h3)
        |-> (pre_q == 3'h7))
        else $error("divide by eight stepped early");

    // Unsynchronised count follows a raw rising input
    a_async_edge: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (cnt_tick && ctl_q[ptm_pkg::CTL_CS] && ctl_q[ptm_pkg::CTL_SYNC_BYP])
        |-> (i_ext_count && !ext_prev_q))
        else $error("async count without input edge");

    // Synchronised external count lands on Q1 only
    a_sync_q1: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (cnt_tick && ctl_q[ptm_pkg::CTL_CS] && !ctl_q[ptm_pkg::CTL_SYNC_BYP])
        |-> (q1 && pend_q))
        else $error("sync count off Q1");

    // A plain step adds exactly one
    a_count_step: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (cnt_tick && !wrap && !wr_lo && !trig)
        |=> (cnt_q == $past(cnt_q) + 16'h0001))
        else $error("count did not step by one");

    // Period low byte takes writes at any time
    a_per_write: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (i_wr && i_addr == ptm_pkg::REG_PER_LO)
        |=> (per_lo_q == $past(i_wdata)))
        else $error("period write refused");

    // High buffer write alone leaves the count alone
    a_hi_write: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (i_wr && i_addr == ptm_pkg::REG_CNT_HI && !cnt_tick && !trig)
        |=> $stable(cnt_q) && (hi_buf_q == $past(i_wdata)))
        else $error("high buffer write touched count");

    // Stopping the timer empties the prescaler
    a_presc_stop: assert property (
        @(posedge i_clk) disable iff (i_rst)
        !run |=> (pre_q == 3'h0))
        else $error("prescaler kept while stopped");

    // Trigger in stopped single-shot sets the run bit
    a_trig_start: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (trig_start && !wr_ctl) |=> run)
        else $error("trigger did not start single shot");

    // Honoured trigger clears the count unless a bus write wins
    a_trig_clear: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (trig && !wr_lo) |=> (cnt_q == 16'h0000))
        else $error("trigger did not clear count");

    // Software clear drops the flag when no match competes
    a_flag_clear: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (i_wr && i_addr == ptm_pkg::REG_STATUS
         && i_wdata[ptm_pkg::STS_MATCH] && !wrap) |=> !flag_q)
        else $error("flag not cleared by software");
endmodule
`default_nettype wire

// File: sim/ptm_ext_src.sv
`timescale 1ns/1ns
`default_nettype none
// External count source: bursts of square pulses, idle low
module ptm_ext_src (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_go,
    input  wire logic [7:0] i_num,
    output logic            o_ext,
    output logic            o_busy
);
    logic [7:0] left_q;
    logic [2:0] tick_q;
    assign o_busy = (left_q != 8'h00);
    // Six clocks high and six low, above half an instruction cycle
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            left_q <= 8'h00;
            tick_q <= 3'h0;
            o_ext  <= 1'b0;
        end else if (i_go) begin
            left_q <= i_num;
            tick_q <= 3'h0;
        end else if (o_busy) begin
            tick_q <= (tick_q == 3'h5) ? 3'h0 : tick_q + 3'h1;
            if (tick_q == 3'h5) begin
                o_ext <= ~o_ext;
            end
            if (tick_q == 3'h5 && o_ext) begin
                left_q <= left_q - 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// File: sim/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic       i_clk;
    logic       i_rst;
    logic [2:0] i_addr;
    logic [7:0] i_wdata;
    logic       i_wr;
    logic       i_rd;
    logic       ext;
    logic       i_trig_reset;
    logic       i_sleep;
    logic       go;
    logic       busy;
    logic [7:0] o_rdata;
    logic       o_match_flag;
    logic       o_running;
    int         error_cnt;
    int         total_checks;
    // Block and its external pulse source
    ptm_timer #(.HAS_TRIG_RESET(1'b1)) dut (.i_clk(i_clk), .i_rst(i_rst),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .i_ext_count(ext), .i_trig_reset(i_trig_reset), .i_sleep(i_sleep),
        .o_rdata(o_rdata), .o_match_flag(o_match_flag),
        .o_running(o_running));
    ptm_ext_src src (.i_clk(i_clk), .i_rst(i_rst), .i_go(go),
        .i_num(8'h0a), .o_ext(ext), .o_busy(busy));
    // Free running clock
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    task automatic complete_run();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, g);
        total_checks++;
        if (g !== e) begin
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
            error_cnt++;
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    task automatic rchk(input logic [2:0] a, input logic [7:0] e, string n);
        logic [7:0] d;
        rd(a, d);
        chk(n, {8'h00, e}, {8'h00, d});
    endtask
    task automatic ld(input logic [15:0] v);
        wr(ptm_pkg::REG_CNT_HI, v[15:8]);
        wr(ptm_pkg::REG_CNT_LO, v[7:0]);
    endtask
    // Bounded wait: flag high, or source done when src is set
    task automatic waitc(input int n, input bit s);
        for (int k = 0; k <= n; k++) begin
            @(posedge i_clk);
            #1;
            if (s ? !busy : (o_match_flag === 1'b1)) return;
        end
        chk("wait timeout", 16'h1, 16'h0);
        complete_run();
    endtask
    task automatic trig();
        @(posedge i_clk);
        i_trig_reset <= 1'b1;
        @(posedge i_clk);
        i_trig_reset <= 1'b0;
        #1;
    endtask
    task automatic t_reset();
        rchk(ptm_pkg::REG_CTRL, 8'h00, "ctrl rst");
        rchk(ptm_pkg::REG_PER_LO, 8'hff, "per lo rst");
        rchk(ptm_pkg::REG_PER_HI, 8'hff, "per hi rst");
        rchk(ptm_pkg::REG_CNT_LO, 8'h00, "cnt rst");
        rchk(3'h6, 8'h00, "unmapped");
    endtask
    task automatic t_rw16();
        ld(16'h1234);
        rchk(ptm_pkg::REG_CNT_LO, 8'h34, "low");
        rchk(ptm_pkg::REG_CNT_HI, 8'h12, "high");
        wr(ptm_pkg::REG_CNT_HI, 8'h56);
        rchk(ptm_pkg::REG_CNT_LO, 8'h34, "low");
        rchk(ptm_pkg::REG_CNT_HI, 8'h12, "high kept");
    endtask
    task automatic t_cont();
        wr(ptm_pkg::REG_PER_HI, 8'h00);
        wr(ptm_pkg::REG_PER_LO, 8'h02);
        ld(16'h0000);
        wr(ptm_pkg::REG_CTRL, 8'h01);
        waitc(40, 1'b0);
        chk("run kept", 16'h1, {15'h0, o_running});
        wr(ptm_pkg::REG_PER_LO, 8'h05);
        rchk(ptm_pkg::REG_PER_LO, 8'h05, "per lo");
        wr(ptm_pkg::REG_CTRL, 8'h00);
        chk("flag held", 16'h1, {15'h0, o_match_flag});
        wr(ptm_pkg::REG_STATUS, 8'h01);
        rchk(ptm_pkg::REG_STATUS, 8'h00, "flag clr");
    endtask
    task automatic t_shot();
        wr(ptm_pkg::REG_PER_LO, 8'h03);
        ld(16'h0000);
        wr(ptm_pkg::REG_CTRL, 8'h21);
        waitc(60, 1'b0);
        chk("shot run", 16'h0, {15'h0, o_running});
        rchk(ptm_pkg::REG_CNT_LO, 8'h00, "shot cnt");
        wr(ptm_pkg::REG_STATUS, 8'h01);
        wr(ptm_pkg::REG_CTRL, 8'h20);
        trig();
        chk("trig start", 16'h1, {15'h0, o_running});
        waitc(60, 1'b0);
        wr(ptm_pkg::REG_CTRL, 8'h60);
        trig();
        chk("trig off", 16'h0, {15'h0, o_running});
        wr(ptm_pkg::REG_CTRL, 8'h00);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= ptm_pkg::REG_CNT_LO;
        i_wdata <= 8'h40;
        i_trig_reset <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        i_trig_reset <= 1'b0;
        rchk(ptm_pkg::REG_CNT_LO, 8'h40, "wr wins");
    endtask
    // Run 32<<p clocks: about eight increments at each prescale
    task automatic t_presc();
        logic [7:0] d;
        wr(ptm_pkg::REG_PER_LO, 8'hff);
        wr(ptm_pkg::REG_PER_HI, 8'hff);
        for (int p = 0; p < 4; p++) begin
            ld(16'h0000);
            wr(ptm_pkg::REG_CTRL, 8'h01 | 8'(p << 3));
            repeat (32 << p) @(posedge i_clk);
            wr(ptm_pkg::REG_CTRL, 8'h00);
            rd(ptm_pkg::REG_CNT_LO, d);
            chk("prescale", 16'h1, {15'h0, d >= 8'h07 && d <= 8'h09});
        end
        repeat (20) @(posedge i_clk);
        wr(ptm_pkg::REG_CTRL, 8'h18);
        rchk(ptm_pkg::REG_CNT_LO, d, "held");
    endtask
    // Ten source pulses per case, with source, bypass and sleep varied
    task automatic t_ext();
        logic [7:0] c [6] = '{8'h03, 8'h07, 8'h87, 8'h83, 8'h07, 8'h81};
        logic       s [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
        logic [7:0] e [6] = '{8'h0a, 8'h0a, 8'h0a, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 6; i++) begin
            ld(16'h0000);
            i_sleep <= s[i];
            wr(ptm_pkg::REG_CTRL, c[i]);
            go <= 1'b1;
            @(posedge i_clk);
            go <= 1'b0;
            waitc(400, 1'b1);
            repeat (8) @(posedge i_clk);
            wr(ptm_pkg::REG_CTRL, 8'h00);
            i_sleep <= 1'b0;
            rchk(ptm_pkg::REG_CNT_LO, e[i], "ext");
        end
    endtask
    // Reset, then the scenarios in turn
    initial begin
        i_rst = 1'b1;
        i_addr = 3'h0;
        i_wdata = 8'h00;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_trig_reset = 1'b0;
        i_sleep = 1'b0;
        go = 1'b0;
        error_cnt = 0;
        total_checks = 0;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        t_reset();
        t_rw16();
        t_cont();
        t_shot();
        t_presc();
        t_ext();
        complete_run();
    end
endmodule
`default_nettype wire
